// ---- include/bmc_map.svh ----
// Register offsets, reset values and fixed values of the status command map
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

`define BMC_ADDR_W          8
`define BMC_DATA_W          16

`define BMC_OFS_CTRL        8'h00
`define BMC_OFS_SUBCMD_LO   8'h3E
`define BMC_OFS_SUBCMD_HI   8'h3F

`define BMC_OFS_SAFE_ALERT1 8'h02
`define BMC_OFS_SAFE_FAULT1 8'h03
`define BMC_OFS_SAFE_ALERT2 8'h04
`define BMC_OFS_SAFE_FAULT2 8'h05
`define BMC_OFS_SAFE_ALERT3 8'h06
`define BMC_OFS_SAFE_FAULT3 8'h07
`define BMC_OFS_PF_ALERT1   8'h0A
`define BMC_OFS_PF_FAULT1   8'h0B
`define BMC_OFS_PF_ALERT2   8'h0C
`define BMC_OFS_PF_FAULT2   8'h0D
`define BMC_OFS_PF_ALERT3   8'h0E
`define BMC_OFS_PF_FAULT3   8'h0F
`define BMC_OFS_PF_ALERT4   8'h10

`define BMC_OFS_ENABLE_BASE 8'h80
`define BMC_OFS_IRQ_STATUS  8'h90
`define BMC_OFS_IRQ_ENABLE  8'h91
`define BMC_OFS_IRQ_CLEAR   8'h92

`define BMC_FLAG_COUNT      13
`define BMC_SAFETY_COUNT    6
`define BMC_IRQ_COUNT       4
`define BMC_IRQ_SUBCMD      0
`define BMC_IRQ_SAFETY      1
`define BMC_IRQ_PERMANENT   2
`define BMC_IRQ_RO_WRITE    3

`define BMC_ECHO_VALUE      16'hFFA5
`define BMC_FLAG_RESET      8'h00
`define BMC_ENABLE_RESET    8'hFF
`define BMC_IRQ_EN_RESET    4'h0

`endif

// ---- include/bmc_pkg.sv ----
// Types shared by the status command map modules
`default_nettype none
package bmc_pkg;

    typedef logic [7:0]  bmc_byte_t;
    typedef logic [15:0] bmc_word_t;
    typedef logic [7:0]  bmc_addr_t;

    // Kind of answer chosen for a read
    typedef enum logic [2:0] {
        BMC_SEL_NONE   = 3'b000,
        BMC_SEL_STATUS = 3'b001,
        BMC_SEL_ECHO   = 3'b010,
        BMC_SEL_FLAG   = 3'b011,
        BMC_SEL_ENABLE = 3'b100,
        BMC_SEL_IRQST  = 3'b101,
        BMC_SEL_IRQEN  = 3'b110
    } bmc_sel_t;

endpackage : bmc_pkg
`default_nettype wire

// ---- src/bmc_reset_sync.sv ----
// Reset synchroniser: asynchronous assertion, release through two flip-flops
`default_nettype none
module bmc_reset_sync (
    input  wire logic sys_clk,
    input  wire logic resetn,
    output var  logic syncResetn
);
    import bmc_pkg::*;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } bmc_rst_state_t;

    bmc_rst_state_t state_reg;
    bmc_rst_state_t state_next;

    always_comb begin
        state_next.stage1 = 1'b1;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign syncResetn = state_reg.stage2;

endmodule : bmc_reset_sync
`default_nettype wire

// ---- src/bmc_irq_ctrl.sv ----
// Sticky interrupt status with enable mask and write-one-to-clear
`default_nettype none
`include "bmc_map.svh"
module bmc_irq_ctrl #(
    parameter int N = `BMC_IRQ_COUNT
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [N-1:0] eventPulse,
    input  wire logic         enableWrite,
    input  wire logic [N-1:0] enableData,
    input  wire logic         clearWrite,
    input  wire logic [N-1:0] clearData,
    output var  logic [N-1:0] irqStatus,
    output var  logic [N-1:0] irqEnable,
    output var  logic         irqOut
);
    import bmc_pkg::*;

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] enable;
        logic         irq;
    } bmc_irq_state_t;

    bmc_irq_state_t state_reg;
    bmc_irq_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (clearWrite) begin
            state_next.status = state_reg.status & ~clearData;
        end
        // A new event wins over a clear in the same cycle
        state_next.status = state_next.status | eventPulse;
        if (enableWrite) begin
            state_next.enable = enableData;
        end
        state_next.irq = |(state_next.status & state_next.enable);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg.status <= '0;
            state_reg.enable <= N'(`BMC_IRQ_EN_RESET);
            state_reg.irq    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign irqStatus = state_reg.status;
    assign irqEnable = state_reg.enable;
    assign irqOut    = state_reg.irq;

endmodule : bmc_irq_ctrl
`default_nettype wire

// ---- src/bmc_status_map.sv ----
// Command-address map: control/status word with write echo, alert and fault flags
//
// Chosen here: the strobed register port.
`default_nettype none
`include "bmc_map.svh"
module bmc_status_map
    import bmc_pkg::*;
#(
    parameter int NFLAG = `BMC_FLAG_COUNT,
    parameter int NSAFE = `BMC_SAFETY_COUNT
) (
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic [7:0]         regAddr,
    input  wire logic [15:0]        regWdata,
    input  wire logic               regWrite,
    input  wire logic               regWordWrite,
    input  wire logic               regRead,
    output var  logic [15:0]        regRdata,
    input  wire logic [15:0]        deviceStatus,
    input  wire logic [NFLAG*8-1:0] flagEvent,
    output var  logic               subcmdValid,
    output var  logic [15:0]        subcmdCode,
    output var  logic               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Flag register index of an address, or NFLAG when it is not a flag
    function automatic logic [3:0] flagIndex(input bmc_addr_t addr);
        logic [3:0] idx;
        idx = 4'(NFLAG);
        case (addr)
            `BMC_OFS_SAFE_ALERT1: idx = 4'h0;
            `BMC_OFS_SAFE_FAULT1: idx = 4'h1;
            `BMC_OFS_SAFE_ALERT2: idx = 4'h2;
            `BMC_OFS_SAFE_FAULT2: idx = 4'h3;
            `BMC_OFS_SAFE_ALERT3: idx = 4'h4;
            `BMC_OFS_SAFE_FAULT3: idx = 4'h5;
            `BMC_OFS_PF_ALERT1:   idx = 4'h6;
            `BMC_OFS_PF_FAULT1:   idx = 4'h7;
            `BMC_OFS_PF_ALERT2:   idx = 4'h8;
            `BMC_OFS_PF_FAULT2:   idx = 4'h9;
            `BMC_OFS_PF_ALERT3:   idx = 4'hA;
            `BMC_OFS_PF_FAULT3:   idx = 4'hB;
            `BMC_OFS_PF_ALERT4:   idx = 4'hC;
            default:              idx = 4'(NFLAG);
        endcase
        return idx;
    endfunction : flagIndex

    // Enable register index of an address, or NFLAG when out of range
    function automatic logic [3:0] enableIndex(input bmc_addr_t addr);
        logic [7:0] diff;
        diff = addr - `BMC_OFS_ENABLE_BASE;
        if (addr >= `BMC_OFS_ENABLE_BASE && diff < 8'(NFLAG)) begin
            return diff[3:0];
        end
        return 4'(NFLAG);
    endfunction : enableIndex

    ////////////////////////////////////////////////////////////////////////////
    // Reset and state

    logic syncResetn;

    bmc_reset_sync u_reset_sync (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .syncResetn (syncResetn)
    );

    typedef struct packed {
        logic [NFLAG-1:0][7:0] flags;
        logic [NFLAG-1:0][7:0] enables;
        logic                  echoPending;
        logic [15:0]           rdata;
        logic                  subValid;
        logic [15:0]           subCode;
        logic [`BMC_IRQ_COUNT-1:0] events;
    } bmc_map_state_t;

    bmc_map_state_t state_reg;
    bmc_map_state_t state_next;

    logic [`BMC_IRQ_COUNT-1:0] irqStatus;
    logic [`BMC_IRQ_COUNT-1:0] irqEnable;
    logic                      irqEnWrite;
    logic                      irqClrWrite;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    bmc_sel_t   readSel;
    logic [3:0] rdFlagIdx;
    logic [3:0] rdEnIdx;
    logic [3:0] wrFlagIdx;
    logic [3:0] wrEnIdx;
    logic [7:0] flagNew;
    logic       safeRise;
    logic       permRise;

    always_comb begin
        state_next  = state_reg;
        readSel     = BMC_SEL_NONE;
        rdFlagIdx   = flagIndex(regAddr);
        rdEnIdx     = enableIndex(regAddr);
        wrFlagIdx   = flagIndex(regAddr);
        wrEnIdx     = enableIndex(regAddr);
        flagNew     = 8'h00;
        safeRise    = 1'b0;
        permRise    = 1'b0;
        irqEnWrite  = 1'b0;
        irqClrWrite = 1'b0;

        // Flag capture: only enabled sources can show
        for (int i = 0; i < NFLAG; i++) begin
            flagNew = flagEvent[i*8 +: 8] & state_reg.enables[i];
            if (i < NSAFE) begin
                // Safety flags follow the enabled condition live
                state_next.flags[i] = flagNew;
                safeRise = safeRise | (|(flagNew & ~state_reg.flags[i]));
            end else begin
                // Permanent-fail flags hold until reset; nothing else clears them
                state_next.flags[i] = state_reg.flags[i] | flagNew;
                permRise = permRise | (|(flagNew & ~state_reg.flags[i]));
            end
        end

        state_next.subValid = 1'b0;
        state_next.events   = '0;
        state_next.events[`BMC_IRQ_SAFETY]    = safeRise;
        state_next.events[`BMC_IRQ_PERMANENT] = permRise;

        if (regWrite) begin
            // Any access after the write ends the echo window
            state_next.echoPending = 1'b0;
            if (regAddr == `BMC_OFS_CTRL) begin
                // Forwarded exactly as a subcommand pair write would be
                state_next.subValid = 1'b1;
                state_next.subCode  = regWordWrite ? regWdata
                                                   : {8'h00, regWdata[7:0]};
                state_next.echoPending = regWordWrite;
                state_next.events[`BMC_IRQ_SUBCMD] = 1'b1;
            end else if (wrFlagIdx != 4'(NFLAG)) begin
                // Read-only in every mode: data dropped, event flagged
                state_next.events[`BMC_IRQ_RO_WRITE] = 1'b1;
            end else if (wrEnIdx != 4'(NFLAG)) begin
                state_next.enables[wrEnIdx] = regWdata[7:0];
            end else if (regAddr == `BMC_OFS_IRQ_ENABLE) begin
                irqEnWrite = 1'b1;
            end else if (regAddr == `BMC_OFS_IRQ_CLEAR) begin
                irqClrWrite = 1'b1;
            end
        end

        if (regRead) begin
            if (regAddr == `BMC_OFS_CTRL) begin
                readSel = state_reg.echoPending ? BMC_SEL_ECHO
                                                : BMC_SEL_STATUS;
            end else if (rdFlagIdx != 4'(NFLAG)) begin
                readSel = BMC_SEL_FLAG;
            end else if (rdEnIdx != 4'(NFLAG)) begin
                readSel = BMC_SEL_ENABLE;
            end else if (regAddr == `BMC_OFS_IRQ_STATUS) begin
                readSel = BMC_SEL_IRQST;
            end else if (regAddr == `BMC_OFS_IRQ_ENABLE) begin
                readSel = BMC_SEL_IRQEN;
            end else begin
                readSel = BMC_SEL_NONE;
            end
            // The echo is given once; whatever is read next clears it
            state_next.echoPending = 1'b0;
        end

        // Read data stand for one cycle only, zero otherwise
        case (readSel)
            BMC_SEL_STATUS: state_next.rdata = deviceStatus;
            BMC_SEL_ECHO:   state_next.rdata = `BMC_ECHO_VALUE;
            BMC_SEL_FLAG:   state_next.rdata = {8'h00, state_reg.flags[rdFlagIdx]};
            BMC_SEL_ENABLE: state_next.rdata = {8'h00, state_reg.enables[rdEnIdx]};
            BMC_SEL_IRQST:  state_next.rdata = {12'h000, irqStatus};
            BMC_SEL_IRQEN:  state_next.rdata = {12'h000, irqEnable};
            BMC_SEL_NONE:   state_next.rdata = 16'h0000;
            default:        state_next.rdata = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge syncResetn) begin
        if (!syncResetn) begin
            for (int i = 0; i < NFLAG; i++) begin
                state_reg.flags[i]   <= `BMC_FLAG_RESET;
                state_reg.enables[i] <= `BMC_ENABLE_RESET;
            end
            state_reg.echoPending <= 1'b0;
            state_reg.rdata       <= 16'h0000;
            state_reg.subValid    <= 1'b0;
            state_reg.subCode     <= 16'h0000;
            state_reg.events      <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    bmc_irq_ctrl #(
        .N (`BMC_IRQ_COUNT)
    ) u_irq_ctrl (
        .sys_clk     (sys_clk),
        .rstn        (syncResetn),
        .eventPulse  (state_reg.events),
        .enableWrite (irqEnWrite),
        .enableData  (regWdata[`BMC_IRQ_COUNT-1:0]),
        .clearWrite  (irqClrWrite),
        .clearData   (regWdata[`BMC_IRQ_COUNT-1:0]),
        .irqStatus   (irqStatus),
        .irqEnable   (irqEnable),
        .irqOut      (irq)
    );

    assign regRdata    = state_reg.rdata;
    assign subcmdValid = state_reg.subValid;
    assign subcmdCode  = state_reg.subCode;

endmodule : bmc_status_map
`default_nettype wire

// ---- tb/bmc_status_map_chk.sv ----
// Port checker for the status command map
`default_nettype none
module bmc_status_map_chk #(
    parameter int NFLAG = 13,
    parameter int NSAFE = 6
) (
    input wire logic               sys_clk,
    input wire logic               resetn,
    input wire logic [7:0]         regAddr,
    input wire logic [15:0]        regWdata,
    input wire logic               regWrite,
    input wire logic               regWordWrite,
    input wire logic               regRead,
    input wire logic [15:0]        regRdata,
    input wire logic [15:0]        deviceStatus,
    input wire logic [NFLAG*8-1:0] flagEvent,
    input wire logic               subcmdValid,
    input wire logic [15:0]        subcmdCode,
    input wire logic               irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [NFLAG*8-1:0]    evD1;
    logic [NFLAG*8-1:0]    evD2;
    logic [NFLAG-1:0][7:0] enSh;
    logic [7:0]            addrD;
    logic [7:0]            evSel;
    logic                  echoP;
    logic                  wr0;
    logic                  rd0;
    logic                  rdSafe;
    logic                  rdPf;
    // A flag read returns the enabled sources seen one edge before the data appear;
    // the enable copy follows host writes so that a masked source is not a lost flag
    always_ff @(posedge sys_clk) begin
        evD1  <= flagEvent & enSh;
        evD2  <= evD1;
        addrD <= regAddr;
        if (!resetn) begin
            enSh  <= '1;
            echoP <= 1'b0;
        end else begin
            if (regWrite && regAddr >= 8'h80 && regAddr < 8'(8'h80 + NFLAG)) begin
                enSh[regAddr[3:0]] <= regWdata[7:0];
            end
            // Any strobe ends the echo window; idle cycles leave it open
            if (regRead || regWrite) begin
                echoP <= wr0;
            end
        end
    end
    assign evSel  = evD2[((addrD < 8'h08) ? addrD - 8'h02 : addrD - 8'h04) * 8 +: 8];
    assign wr0    = regWrite && regWordWrite && (regAddr == 8'h00);
    assign rd0    = regRead && (regAddr == 8'h00);
    assign rdSafe = regRead && (regAddr inside {[8'h02:8'h07]});
    assign rdPf   = regRead && (regAddr inside {[8'h0A:8'h10]});
    sequence sWr0;
        wr0;
    endsequence
    sequence sRd0;
        rd0;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_status_read: assert property (
        rd0 && !echoP |=> regRdata == $past(deviceStatus))
        else $error("status word read mismatch");
    a_subcmd_fwd: assert property (
        sWr0 |=> subcmdValid && subcmdCode == $past(regWdata))
        else $error("write to zero not forwarded");
    a_subcmd_only: assert property (
        subcmdValid |-> $past(regWrite) && $past(regAddr) == 8'h00)
        else $error("subcommand pulse without a write to zero");
    a_echo_once: assert property (sWr0 ##1 sRd0 |=> regRdata == 16'hFFA5)
        else $error("echo value missing");
    a_echo_late: assert property (rd0 && echoP |=> regRdata == 16'hFFA5)
        else $error("pending echo not returned");
    a_echo_gone: assert property (
        sWr0 ##1 sRd0 ##1 sRd0 |=> regRdata == $past(deviceStatus))
        else $error("echo value repeated");
    a_safety_flags: assert property (rdSafe |=> regRdata == {8'h00, evSel})
        else $error("safety flag differs from its enabled source");
    a_pf_flags: assert property (
        rdPf |=> (regRdata[7:0] & evSel) == evSel && regRdata[15:8] == 8'h00)
        else $error("permanent flag lost its source");
    a_flags_kept: assert property (
        rdPf ##1 (rdPf && $stable(regAddr))
        |=> (regRdata[7:0] & $past(regRdata[7:0])) == $past(regRdata[7:0]))
        else $error("read cleared a permanent flag");
endmodule : bmc_status_map_chk
bind bmc_status_map bmc_status_map_chk #(.NFLAG(NFLAG), .NSAFE(NSAFE)) i_chk (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regWordWrite(regWordWrite), .regRead(regRead),
    .regRdata(regRdata), .deviceStatus(deviceStatus), .flagEvent(flagEvent),
    .subcmdValid(subcmdValid), .subcmdCode(subcmdCode), .irq(irq));
`default_nettype wire

// ---- tb/bmc_host_model.sv ----
// Host controller model: issues register bus cycles and collects read data
`default_nettype none
module bmc_host_model (
    input  wire logic        sys_clk,
    output var  logic [7:0]  regAddr,
    output var  logic [15:0] regWdata,
    output var  logic        regWrite,
    output var  logic        regWordWrite,
    output var  logic        regRead,
    input  wire logic [15:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        rdTaken;
    logic [15:0] rdQ[$];
    // Strobes stay as set so that calls run back to back; an idle call ends a burst
    task automatic cyc(input logic rd, input logic wr, input logic wd,
                       input logic [7:0] a, input logic [15:0] d);
        regRead      <= rd;
        regWrite     <= wr;
        regWordWrite <= wd;
        regAddr      <= a;
        regWdata     <= d;
        @(posedge sys_clk);
    endtask : cyc
    // Address zero is written only for legacy detection
    task automatic detect(input logic [15:0] code, input logic word);
        cyc(1'b0, 1'b1, word, 8'h00, code);
    endtask : detect
    always @(posedge sys_clk) rdTaken <= regRead;
    always @(negedge sys_clk) if (rdTaken) rdQ.push_back(regRdata);
endmodule : bmc_host_model
`default_nettype wire

// ---- tb/bmc_status_map_tb_top.sv ----
// Self-checking bench of the status command map
`default_nettype none
`include "bmc_map.svh"
module bmc_status_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NF = `BMC_FLAG_COUNT;
    logic [7:0]      regAddr;
    logic [15:0]     regWdata, regRdata, deviceStatus, subcmdCode, code, got, want;
    logic            sys_clk, resetn, regWrite, regWordWrite, regRead, subcmdValid, irq;
    logic [NF*8-1:0] flagEvent, ev;
    logic [7:0]      pfAcc[NF];
    int              errors, comparisons, seed, k, j;
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    bmc_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regWordWrite(regWordWrite), .regRead(regRead),
        .regRdata(regRdata));
    bmc_status_map i_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regWordWrite(regWordWrite),
        .regRead(regRead), .regRdata(regRdata), .deviceStatus(deviceStatus),
        .flagEvent(flagEvent), .subcmdValid(subcmdValid), .subcmdCode(subcmdCode),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fAddr(input int i);
        return (i < 6) ? 8'(8'h02 + i) : 8'(8'h04 + i);
    endfunction : fAddr
    function automatic logic [7:0] expFlag(input int i);
        return (i < 6) ? ev[i*8 +: 8] : pfAcc[i];
    endfunction : expFlag
    task automatic stop_test;
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic chkW(input logic [15:0] g, input logic [15:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chkW
    task automatic chkB(input logic g, input logic e, input string m);
        chkW({15'h0000, g}, {15'h0000, e}, m);
    endtask : chkB
    task automatic popChk(input logic [15:0] e, input string m);
        got = (i_host.rdQ.size() > 0) ? i_host.rdQ.pop_front() : 16'hXXXX;
        chkW(got, e, m);
    endtask : popChk
    task automatic rdChk(input logic [7:0] a, input logic [15:0] e, input string m);
        i_host.cyc(1'b1, 1'b0, 1'b0, a, 16'h0000);
        i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        popChk(e, m);
    endtask : rdChk
    // Interrupt level is sampled mid-cycle, well clear of the edge that moves it
    task automatic irqChk(input logic e, input string m);
        i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chkB(irq, e, m);
        @(posedge sys_clk);
    endtask : irqChk
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        errors++;
        stop_test();
    end
    initial begin
        {errors, comparisons, seed} = {32'd0, 32'd0, 32'd12839};
        {resetn, deviceStatus, flagEvent, ev} = '0;
        foreach (pfAcc[i]) pfAcc[i] = 8'h00;
        // The host model's pins are driven from this process only
        i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (k = 0; k < 8; k++) begin
            deviceStatus <= (k == 0) ? 16'hFFA5 : 16'($random(seed));
            @(posedge sys_clk);
            rdChk(8'h00, deviceStatus, "status");
        end
        // Echo, echo consumed by another read, byte write without echo, echo after idle
        for (k = 0; k < 4; k++) begin
            code = 16'($random(seed));
            i_host.detect(code, k != 2);
            if (k == 3) i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
            i_host.cyc(1'b1, 1'b0, 1'b0, (k == 1) ? 8'h02 : 8'h00, 16'h0000);
            i_host.cyc(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000);
            i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
            want = (k == 1) ? 16'h0000 : (k == 2) ? deviceStatus : `BMC_ECHO_VALUE;
            popChk(want, "read 1");
            popChk(deviceStatus, "read 2");
            chkW(subcmdCode, (k == 2) ? {8'h00, code[7:0]} : code, "code");
        end
        // Last round drops all sources: safety flags follow, permanent ones stay
        for (k = 0; k < 4; k++) begin
            for (j = 0; j < NF; j++) begin
                ev[j*8 +: 8] = (k == 3) ? 8'h00 : 8'($random(seed));
                if (j >= 6) pfAcc[j] = pfAcc[j] | ev[j*8 +: 8];
            end
            flagEvent <= ev;
            repeat (2) @(posedge sys_clk);
            for (j = 0; j < NF; j++) begin
                i_host.cyc(1'b0, 1'b1, 1'b1, fAddr(j), 16'hFFFF);
                i_host.cyc(1'b1, 1'b0, 1'b0, fAddr(j), 16'h0000);
                i_host.cyc(1'b1, 1'b0, 1'b0, fAddr(j), 16'h0000);
                i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
                popChk({8'h00, expFlag(j)}, "flag");
                popChk({8'h00, expFlag(j)}, "flag again");
            end
        end
        ev[7:0] = 8'hA5;
        flagEvent <= ev;
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h80, 16'h000F);
        i_host.cyc(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        rdChk(8'h02, 16'h0005, "masked flag");
        rdChk(8'h80, 16'h000F, "enable");
        rdChk(8'h3E, 16'h0000, "unmapped");
        rdChk(8'h91, 16'h0000, "irq enable reset");
        flagEvent <= '0;
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h80, 16'h00FF);
        irqChk(1'b0, "irq quiet");
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h92, 16'h000F);
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h91, 16'h0001);
        i_host.detect(16'h1234, 1'b1);
        irqChk(1'b1, "irq raised");
        rdChk(8'h90, 16'h0001, "irq status");
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h91, 16'h0000);
        irqChk(1'b0, "irq masked");
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h91, 16'h0001);
        i_host.cyc(1'b0, 1'b1, 1'b0, 8'h92, 16'h0001);
        irqChk(1'b0, "irq cleared");
        rdChk(8'h90, 16'h0000, "irq status cleared");
        stop_test();
    end
endmodule : bmc_status_map_tb_top
`default_nettype wire
